// file: fpc_ac_mod.sv
// AC modulation phase generator for the flat panel
`timescale 1ns/1ps
`default_nettype none
module fpc_ac_mod (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Modulation link
   fpc_mod_if.gen    m
);
   logic [7:0] cnt_r;      // Line pulses since last phase change
   logic [7:0] cnt_nxt;
   logic       tog_r;      // Phase flop
   logic       per_zero;   // Zero period means once per frame
   logic       cnt_done;   // Programmed line count reached
   logic       flip;       // Phase change this cycle

   assign per_zero = (m.period == 8'h00);
   assign cnt_done = m.line_pulse && ((cnt_r + 8'h01) >= m.period);
   assign flip     = per_zero ? m.frame_start : cnt_done;
   assign cnt_nxt  = (per_zero || cnt_done) ? 8'h00 :
                     (m.line_pulse ? cnt_r + 8'h01 : cnt_r);
   assign m.toggle = tog_r;

   // Count lines and flip the phase; counter restarts on each flip
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         tog_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tog_r <= tog_r ^ flip;
      end
   end

   a_mod_frame_flip : assert property (@(posedge clock) disable iff (rst)
      per_zero && m.frame_start |=> tog_r != $past(tog_r))
      else $error("modulation phase did not flip at frame start");
   a_mod_line_hold : assert property (@(posedge clock) disable iff (rst)
      !per_zero && !m.line_pulse |=> $stable(tog_r))
      else $error("modulation phase changed without a line pulse");
endmodule : fpc_ac_mod
`default_nettype wire

// file: fpc_mod_if.sv
// Interface between the register bank and the AC modulation generator
`timescale 1ns/1ps
`default_nettype none
interface fpc_mod_if;
   logic       line_pulse;   // One-cycle line pulse
   logic       frame_start;  // One-cycle frame start
   logic [7:0] period;       // Lines between phase changes
   logic       toggle;       // Modulation phase
   modport ctl (output line_pulse, output frame_start, output period, input toggle);
   modport gen (input line_pulse, input frame_start, input period, output toggle);
endinterface : fpc_mod_if
`default_nettype wire

// file: fpc_panel_model.sv
// Behavioural flat panel that counts line clocks and drive phase changes
`timescale 1ns/1ps
`default_nettype none
module fpc_panel_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Panel strobes
   input  wire logic       panel_line_clock,
   input  wire logic       ac_drive_toggle,
   // Counts seen by the panel
   output logic      [7:0] lines_seen,
   output logic      [7:0] flips_seen
);
   logic toggle_q;  // Last drive phase, for change detection
   // Strobes are one-cycle pulses, so counting high cycles counts pulses
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lines_seen <= 8'h00;
         flips_seen <= 8'h00;
         toggle_q   <= 1'b0;
      end else begin
         lines_seen <= lines_seen + {7'h00, panel_line_clock};
         flips_seen <= flips_seen + {7'h00, ac_drive_toggle ^ toggle_q};
         toggle_q   <= ac_drive_toggle;
      end
   end
endmodule : fpc_panel_model
`default_nettype wire

// file: fpc_panel_regs.sv
// Flat-panel control register bank with its panel-side controls
`timescale 1ns/1ps
`default_nettype none
module fpc_panel_regs (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Indexed host port, same clock
   input  wire logic       host_data_sel,
   input  wire logic       host_wr,
   input  wire logic       host_rd,
   input  wire logic [7:0] host_wdata,
   input  wire logic       regs_unlocked,
   output logic      [7:0] host_rdata,
   // Display timing from the CRT controller
   input  wire logic       line_pulse_in,
   input  wire logic       frame_start_in,
   input  wire logic       hsync_in,
   input  wire logic       vsync_in,
   input  wire logic       equalize_in,
   input  wire logic       upper_frame_end,
   // Mode context
   input  wire logic [2:0] panel_type,
   input  wire logic [1:0] misc_output_reg,
   input  wire logic       ext_vtiming_en,
   input  wire logic       text_mode,
   // Pixel and attribute data
   input  wire logic [3:0] palette_gray,
   input  wire logic [3:0] rgbi_in,
   input  wire logic [3:0] fg_gray,
   input  wire logic [3:0] bg_gray,
   // Panel interface controls
   output logic            stn8_color,
   output logic            stn_enh_timing,
   output logic            crt_enable,
   output logic            panel_enable,
   output logic            plasma_8bit,
   output logic            gray_conv_alt,
   output logic            tv_enable,
   // Panel strobes
   output logic            hsync_out,
   output logic            line_pulse,
   output logic            frame_start_marker,
   output logic            panel_line_clock,
   output logic            ac_drive_toggle,
   // Display shaping
   output logic            blink_phase,
   output logic            full_cursor,
   output logic            vexpand,
   output logic            hexpand,
   output logic            char_8dot,
   output logic            panel_800,
   output logic            ext_group_480,
   output logic            ext_group_600,
   // Frame buffer mode
   output logic            shadow_mono,
   output logic            shadow_color,
   output logic            ext_fbuf,
   output logic            pseudo_fbuf,
   // Pixel results
   output logic      [3:0] pixel_out,
   output logic      [3:0] fg_out,
   output logic      [3:0] bg_out
);
   // Register storage, slot 0 holds index 0xa1
   localparam int NUM_REGS_W = fpc_pkg::NUM_REGS;
   logic [NUM_REGS_W-1:0][7:0] regs_r;
   logic [7:0] idx_r;          // Index port contents
   logic [7:0] rdata_r;        // Read data flop
   logic [7:0] slot_full;      // Index minus base
   logic [2:0] slot;           // Register slot
   logic       idx_hit;        // Index falls in this bank
   logic       idx_wr;         // Index port write
   logic       data_wr;        // Accepted data port write
   logic [7:0] rd_sel;         // Data port read value
   logic [7:0] r_if;           // Named views of the bank
   logic [7:0] r_em;
   logic [7:0] r_xb;
   logic [7:0] r_rt;

   // Host decode
   assign slot_full = idx_r - fpc_pkg::IDX_IFSEL;
   assign slot      = slot_full[2:0];
   assign idx_hit   = (idx_r >= fpc_pkg::IDX_IFSEL) && (idx_r <= fpc_pkg::IDX_SPARE);
   assign idx_wr    = host_wr && !host_data_sel;
   // Locked bank drops data writes silently
   assign data_wr   = host_wr && host_data_sel && idx_hit && regs_unlocked;
   assign rd_sel    = idx_hit ? regs_r[slot] : fpc_pkg::RD_UNMAPPED;
   assign r_if      = regs_r[0];
   assign r_em      = regs_r[1];
   assign r_xb      = regs_r[2];
   assign r_rt      = regs_r[4];

   // Index register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         idx_r <= 8'h00;
      end else if (idx_wr) begin
         idx_r <= host_wdata;
      end
   end

   // One flop per register, written through the data port
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS_W; gi++) begin : g_reg
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               regs_r[gi] <= fpc_pkg::REG_RST[gi];
            end else if (data_wr && (slot == 3'(gi))) begin
               regs_r[gi] <= host_wdata;
            end
         end
      end
   endgenerate

   // Read data registered; index port reads back the index
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (host_rd) begin
         rdata_r <= host_data_sel ? rd_sel : idx_r;
      end
   end
   assign host_rdata = rdata_r;

   // Panel strobe selection
   logic tft_sync;     // CRT-like strobes requested
   logic lp_sel;       // Chosen line pulse
   logic fm_sel;       // Chosen frame marker
   logic csync;        // Composite sync
   logic hs_sel;       // Hsync pin source
   logic extra_en;     // Any extra line clock requested
   logic extra_pend_r; // Extra clock follows the upper frame

   assign tft_sync = r_if[fpc_pkg::B_TFTSYNC];
   // TFT strobes shaped like CRT sync
   assign lp_sel   = tft_sync ? hsync_in : line_pulse_in;
   assign fm_sel   = tft_sync ? vsync_in : frame_start_in;
   // Equalizing pulses replace hsync while vsync is active
   assign csync    = vsync_in ? (r_rt[fpc_pkg::B_EQUAL] ? ~equalize_in : 1'b1)
                              : hsync_in;
   assign hs_sel   = r_if[fpc_pkg::B_TVON] ? csync : hsync_in;
   assign extra_en = r_xb[fpc_pkg::B_XTRA244] || r_xb[fpc_pkg::B_XTRA242];

   // Strobe flops; extra clock lands two cycles after the frame end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         extra_pend_r       <= 1'b0;
         line_pulse         <= 1'b0;
         frame_start_marker <= 1'b0;
         panel_line_clock   <= 1'b0;
         hsync_out          <= 1'b0;
      end else begin
         extra_pend_r       <= upper_frame_end && extra_en;
         line_pulse         <= lp_sel;
         frame_start_marker <= fm_sel;
         panel_line_clock   <= lp_sel || extra_pend_r;
         hsync_out          <= hs_sel;
      end
   end

   // AC modulation generator shares the raw line pulse
   fpc_mod_if mod_link ();
   assign mod_link.line_pulse  = line_pulse_in;
   assign mod_link.frame_start = frame_start_in;
   assign mod_link.period      = regs_r[3];
   assign ac_drive_toggle      = mod_link.toggle;

   fpc_ac_mod u_ac_mod (
      .clock (clock),
      .rst   (rst),
      .m     (mod_link.gen)
   );

   // Blink phase from a free frame counter
   logic [6:0] frm_cnt_r;    // Frames seen
   logic [1:0] blink_sel;    // Rate field
   logic [6:0] blink_shift;  // Counter scaled by rate
   logic       blink_nxt;

   assign blink_sel   = r_em[fpc_pkg::B_BLINK +: 2];
   // Each step of the field doubles the blink period
   assign blink_shift = frm_cnt_r >> blink_sel;
   assign blink_nxt   = blink_shift[fpc_pkg::BLINK_BIT0];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frm_cnt_r   <= 7'h00;
         blink_phase <= 1'b0;
      end else begin
         if (frame_start_in) begin
            frm_cnt_r <= frm_cnt_r + 7'h01;
         end
         blink_phase <= blink_nxt;
      end
   end

   // Gray path selection
   logic       gray_bypass; // Skip gray palette
   logic       rev_on;      // Reverse video active
   logic [3:0] gray_src;
   logic [3:0] gray_fin;
   logic       con_force;   // Contrast override applies
   logic       vgrp_valid;  // Extended group chosen by this bank
   logic       dual_color;
   logic       dual_mono;

   // Emulation bypasses the palette; RGBI packs as a gray code
   assign gray_bypass = text_mode ? r_em[fpc_pkg::B_ATTREM]
                                  : r_em[fpc_pkg::B_RGBIEM];
   assign gray_src    = gray_bypass ? {rgbi_in[3], rgbi_in[1], rgbi_in[2], rgbi_in[0]}
                                    : palette_gray;
   assign rev_on      = text_mode ? r_em[fpc_pkg::B_REVTXT] : r_em[fpc_pkg::B_REVGFX];
   assign gray_fin    = rev_on ? ~gray_src : gray_src;
   // Alternative gray conversion disables the contrast override
   assign con_force   = text_mode && r_em[fpc_pkg::B_MAXCON] && !r_if[fpc_pkg::B_GRAYALT]
                        && (fg_gray > bg_gray);
   assign vgrp_valid  = ext_vtiming_en && (misc_output_reg == fpc_pkg::MISC_EXT_GRP);
   assign dual_color  = (panel_type == fpc_pkg::PT_DUAL_COLOR);
   assign dual_mono   = (panel_type == fpc_pkg::PT_DUAL_MONO);

   // Pixel result flops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pixel_out <= 4'h0;
         fg_out    <= 4'h0;
         bg_out    <= 4'h0;
      end else begin
         pixel_out <= gray_fin;
         fg_out    <= con_force ? fpc_pkg::GRAY_MAX : fg_gray;
         bg_out    <= con_force ? fpc_pkg::GRAY_MIN : bg_gray;
      end
   end

   // Control outputs, registered so the pins never glitch
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stn8_color     <= 1'b0;
         stn_enh_timing <= 1'b0;
         crt_enable     <= 1'b1;
         panel_enable   <= 1'b0;
         plasma_8bit    <= 1'b0;
         gray_conv_alt  <= 1'b0;
         tv_enable      <= 1'b0;
         full_cursor    <= 1'b0;
         vexpand        <= 1'b0;
         hexpand        <= 1'b0;
         char_8dot      <= 1'b0;
         panel_800      <= 1'b0;
         ext_group_480  <= 1'b0;
         ext_group_600  <= 1'b0;
         shadow_mono    <= 1'b0;
         shadow_color   <= 1'b0;
         ext_fbuf       <= 1'b0;
         pseudo_fbuf    <= 1'b0;
      end else begin
         stn8_color     <= r_if[fpc_pkg::B_STN8];
         stn_enh_timing <= r_if[fpc_pkg::B_STNENH];
         crt_enable     <= !r_if[fpc_pkg::B_CRTOFF];
         panel_enable   <= r_if[fpc_pkg::B_PANELON];
         plasma_8bit    <= r_if[fpc_pkg::B_PLASMA8];
         gray_conv_alt  <= r_if[fpc_pkg::B_GRAYALT];
         tv_enable      <= r_if[fpc_pkg::B_TVON];
         full_cursor    <= r_em[fpc_pkg::B_FULLCUR];
         vexpand        <= text_mode ? r_xb[fpc_pkg::B_VEXTXT] : r_xb[fpc_pkg::B_VEXGFX];
         hexpand        <= text_mode ? r_rt[fpc_pkg::B_HEXTXT] : r_rt[fpc_pkg::B_HEXGFX];
         char_8dot      <= r_xb[fpc_pkg::B_DOT8];
         panel_800      <= r_rt[fpc_pkg::B_RES800];
         ext_group_480  <= vgrp_valid && !r_rt[fpc_pkg::B_GRP600];
         ext_group_600  <= vgrp_valid && r_rt[fpc_pkg::B_GRP600];
         // Buffer modes only mean something on dual-scan panels
         shadow_mono    <= dual_mono && r_xb[fpc_pkg::B_SHMONO];
         shadow_color   <= dual_color && r_xb[fpc_pkg::B_SHCOL];
         ext_fbuf       <= dual_color && r_xb[fpc_pkg::B_EXTBUF];
         pseudo_fbuf    <= dual_color && !r_xb[fpc_pkg::B_EXTBUF];
      end
   end

   // Checks on the bank behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_wr_ifsel;
      host_wr && host_data_sel && regs_unlocked && (idx_r == fpc_pkg::IDX_IFSEL);
   endsequence
   sequence s_wr_locked;
      host_wr && host_data_sel && !regs_unlocked;
   endsequence

   a_crt_panel_enable : assert property (s_wr_ifsel |=> ##1
      (crt_enable == !$past(host_wdata[3], 2)) && (panel_enable == $past(host_wdata[4], 2)))
      else $error("crt or panel enable does not follow the write");
   a_plasma_width : assert property (s_wr_ifsel |-> ##2
      plasma_8bit == $past(host_wdata[5], 2))
      else $error("plasma width does not follow the write");
   a_locked_write : assert property (s_wr_locked |=> $stable(regs_r))
      else $error("locked bank accepted a write");
   a_contrast_force : assert property (con_force |=>
      fg_out == fpc_pkg::GRAY_MAX && bg_out == fpc_pkg::GRAY_MIN)
      else $error("contrast override not applied");
   a_reverse_text : assert property (text_mode && r_em[fpc_pkg::B_REVTXT]
      && !r_em[fpc_pkg::B_ATTREM] |=> pixel_out == ~$past(palette_gray))
      else $error("text reverse video not applied");
   a_tv_hsync_pass : assert property (r_if[fpc_pkg::B_TVON] && !vsync_in |=>
      hsync_out == $past(hsync_in))
      else $error("composite sync wrong outside vsync");
   a_equalize_pulse : assert property (r_if[fpc_pkg::B_TVON] && r_rt[fpc_pkg::B_EQUAL]
      && vsync_in |=> hsync_out == !$past(equalize_in))
      else $error("equalizing pulse not inserted");
   a_extra_clock : assert property (upper_frame_end && extra_en |-> ##2
      panel_line_clock)
      else $error("extra line clock missing");
   a_tft_strobes : assert property (tft_sync |=>
      line_pulse == $past(hsync_in) && frame_start_marker == $past(vsync_in))
      else $error("CRT-like strobes not selected");
   a_vgroup_select : assert property (vgrp_valid && !r_rt[fpc_pkg::B_GRP600] |=>
      ext_group_480 && !ext_group_600)
      else $error("480-line group not selected");
endmodule : fpc_panel_regs
`default_nettype wire

// file: fpc_pkg.sv
// Constants and field layout for the flat-panel control register bank
// Function
// - Colour bit selects 8-bit colour STN interface
// - Enhanced bit selects enhanced colour STN timing
// - Strobe bit gives CRT-like line/frame pulses
// - CRT-disable and panel-enable bits gate outputs
// - Plasma width bit picks 8 or 4 bits
// - Gray-conversion bit applies alternative mono conversion
// - TV bit puts composite sync on hsync
// - Reverse bits invert text or graphic pixels
// - Two-bit field picks blink rate 1/16..1/128
// - Max contrast forces text foreground max, background min when foreground is brighter and the gray-conversion bit is clear
// - Attribute emulation maps RGBI to 16 grays
// - RGBI emulation gives 16 grays in graphics
// - Full-cursor bit forces full-height text cursor
// - Expansion bits per mode stretch vertical/horizontal
// - Narrow bit forces 8-dot character cell
// - Shadow bits enable line buffer, dual-scan only
// - External-buffer bit picks external or pseudo buffer
// - Extra-clock bits add one upper-panel line clock
// - Period register sets modulation toggle; zero per frame
// - Resolution bit picks 640 or 800 panel
// - Group bit picks 480 or 600 line timing
// - Equalizing bit inserts pulses into composite sync
package fpc_pkg;
   // Register indices as seen through the index port
   localparam logic [7:0] IDX_IFSEL  = 8'ha1;
   localparam logic [7:0] IDX_EMUL   = 8'ha2;
   localparam logic [7:0] IDX_EXPBUF = 8'ha3;
   localparam logic [7:0] IDX_ACPER  = 8'ha4;
   localparam logic [7:0] IDX_RESTIM = 8'ha5;
   localparam logic [7:0] IDX_SPARE  = 8'ha6;
   localparam int         NUM_REGS   = 6;
   // Reset values, slot 0 is the interface select register
   localparam logic [NUM_REGS-1:0][7:0] REG_RST = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Interface select fields
   localparam int B_STN8    = 0;
   localparam int B_STNENH  = 1;
   localparam int B_TFTSYNC = 2;
   localparam int B_CRTOFF  = 3;
   localparam int B_PANELON = 4;
   localparam int B_PLASMA8 = 5;
   localparam int B_GRAYALT = 6;
   localparam int B_TVON    = 7;
   // Emulation control fields
   localparam int B_REVTXT  = 0;
   localparam int B_REVGFX  = 1;
   localparam int B_BLINK   = 2;
   localparam int B_MAXCON  = 4;
   localparam int B_ATTREM  = 5;
   localparam int B_RGBIEM  = 6;
   localparam int B_FULLCUR = 7;
   // Expansion and buffer fields
   localparam int B_VEXTXT  = 0;
   localparam int B_VEXGFX  = 1;
   localparam int B_DOT8    = 2;
   localparam int B_SHMONO  = 3;
   localparam int B_SHCOL   = 4;
   localparam int B_EXTBUF  = 5;
   localparam int B_XTRA244 = 6;
   localparam int B_XTRA242 = 7;
   // Resolution and timing fields
   localparam int B_RES800  = 0;
   localparam int B_GRP600  = 1;
   localparam int B_HEXTXT  = 2;
   localparam int B_HEXGFX  = 3;
   localparam int B_EQUAL   = 4;
   // Panel type codes from the first panel control register
   localparam logic [2:0] PT_DUAL_MONO  = 3'h0;
   localparam logic [2:0] PT_DUAL_COLOR = 3'h6;
   // Extended vertical timing selected by both misc output bits
   localparam logic [1:0] MISC_EXT_GRP  = 2'h3;
   // Gray extremes and blink counter base bit (1/16 of frames)
   localparam logic [3:0] GRAY_MAX   = 4'hf;
   localparam logic [3:0] GRAY_MIN   = 4'h0;
   localparam int         BLINK_BIT0 = 3;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage : fpc_pkg

// file: tb_flat_panel_control_regs.sv
// Self-checking bench for the flat-panel control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_flat_panel_control_regs;
   logic       clock, rst, host_data_sel, host_wr, host_rd, regs_unlocked;
   logic       line_pulse_in, frame_start_in, hsync_in, vsync_in, equalize_in;
   logic       upper_frame_end, ext_vtiming_en, text_mode;
   logic [7:0] host_wdata, host_rdata, lines_seen, flips_seen, n, t;
   logic [2:0] panel_type;
   logic [1:0] misc_output_reg;
   logic [3:0] palette_gray, rgbi_in, fg_gray, bg_gray, pixel_out, fg_out, bg_out;
   logic       stn8_color, stn_enh_timing, crt_enable, panel_enable, plasma_8bit;
   logic       gray_conv_alt, tv_enable, hsync_out, line_pulse, frame_start_marker;
   logic       panel_line_clock, ac_drive_toggle, blink_phase, full_cursor, vexpand;
   logic       hexpand, char_8dot, panel_800, ext_group_480, ext_group_600;
   logic       shadow_mono, shadow_color, ext_fbuf, pseudo_fbuf, b;
   int         err_count = 0;  // Mismatches seen
   int         tests_run = 0;  // Comparisons made
   fpc_panel_regs dut (.clock, .rst, .host_data_sel, .host_wr, .host_rd, .host_wdata,
      .regs_unlocked, .host_rdata, .line_pulse_in, .frame_start_in, .hsync_in, .vsync_in,
      .equalize_in, .upper_frame_end, .panel_type, .misc_output_reg, .ext_vtiming_en,
      .text_mode, .palette_gray, .rgbi_in, .fg_gray, .bg_gray, .stn8_color,
      .stn_enh_timing, .crt_enable, .panel_enable, .plasma_8bit, .gray_conv_alt,
      .tv_enable, .hsync_out, .line_pulse, .frame_start_marker, .panel_line_clock,
      .ac_drive_toggle, .blink_phase, .full_cursor, .vexpand, .hexpand, .char_8dot,
      .panel_800, .ext_group_480, .ext_group_600, .shadow_mono, .shadow_color,
      .ext_fbuf, .pseudo_fbuf, .pixel_out, .fg_out, .bg_out);
   fpc_panel_model panel (.clock, .rst, .panel_line_clock, .ac_drive_toggle,
      .lines_seen, .flips_seen);
   // 125 MHz clock
   always #4 clock = ~clock;
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Verdict and end of run
   task automatic conclude;
      if (err_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // One host access: strobe raised after an edge, taken at the next one
   task automatic acc(input logic s, input logic w, input logic [7:0] d);
      @(posedge clock);
      host_data_sel <= s;
      host_wr       <= w;
      host_rd       <= !w;
      host_wdata    <= d;
      @(posedge clock);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
   endtask : acc
   // Index first, then the data port
   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      acc(1'b0, 1'b1, idx);
      acc(1'b1, 1'b1, d);
   endtask : wreg
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      acc(1'b0, 1'b1, idx);
      acc(1'b1, 1'b0, 8'h00);
      #1 check(host_rdata, exp);
   endtask : rchk
   // Derived outputs follow a register two edges later
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask : settle
   // One-cycle timing strobe: bit 0 line, bit 1 frame, bit 2 upper frame end
   task automatic strobe(input logic [2:0] k);
      @(posedge clock);
      {upper_frame_end, frame_start_in, line_pulse_in} <= k;
      @(posedge clock);
      {upper_frame_end, frame_start_in, line_pulse_in} <= 3'h0;
      @(posedge clock);
      #1;
   endtask : strobe
   // Watchdog, generous against some 1850 cycles of tests
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      conclude();
   end
   // Main sequence
   initial begin
      {clock, host_data_sel, host_wr, host_rd, regs_unlocked, line_pulse_in} = '0;
      {frame_start_in, hsync_in, vsync_in, equalize_in, upper_frame_end} = '0;
      {ext_vtiming_en, text_mode, host_wdata, panel_type, misc_output_reg} = '0;
      {palette_gray, rgbi_in, fg_gray, bg_gray} = '0;
      rst = 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      #1 check({7'h00, crt_enable}, 8'h01);
      for (int i = 0; i < 6; i++) rchk(fpc_pkg::IDX_IFSEL + 8'(i), fpc_pkg::REG_RST[i]);
      regs_unlocked <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wreg(fpc_pkg::IDX_IFSEL + 8'(i), 8'h5a ^ 8'(i));
         rchk(fpc_pkg::IDX_IFSEL + 8'(i), 8'h5a ^ 8'(i));
      end
      acc(1'b0, 1'b0, 8'h00);
      #1 check(host_rdata, fpc_pkg::IDX_SPARE);
      regs_unlocked <= 1'b0;
      wreg(fpc_pkg::IDX_ACPER, 8'hff);
      regs_unlocked <= 1'b1;
      rchk(fpc_pkg::IDX_ACPER, 8'h59);
      wreg(8'ha7, 8'hff);
      rchk(8'ha7, 8'h00);
      // Walk a one through the interface select register; bit 2 is a strobe shape
      for (int i = 0; i < 8; i++) begin
         wreg(fpc_pkg::IDX_IFSEL, 8'h01 << i);
         settle();
         check({tv_enable, gray_conv_alt, plasma_8bit, panel_enable, !crt_enable, 1'b0,
            stn_enh_timing, stn8_color}, (8'h01 << i) & 8'hfb);
      end
      hsync_in <= 1'b1;
      vsync_in <= 1'b1;
      @(posedge clock);
      #1 check({6'h00, line_pulse, frame_start_marker}, 8'h00);
      wreg(fpc_pkg::IDX_IFSEL, 8'h04);
      settle();
      check({6'h00, line_pulse, frame_start_marker}, 8'h03);
      // Composite sync during vertical sync
      hsync_in    <= 1'b0;
      equalize_in <= 1'b1;
      wreg(fpc_pkg::IDX_IFSEL, 8'h80);
      wreg(fpc_pkg::IDX_RESTIM, 8'h10);
      settle();
      check({7'h00, hsync_out}, 8'h00);
      wreg(fpc_pkg::IDX_RESTIM, 8'h00);
      settle();
      check({7'h00, hsync_out}, 8'h01);
      wreg(fpc_pkg::IDX_IFSEL, 8'h00);
      settle();
      check({7'h00, hsync_out}, 8'h00);
      // Pixel path
      text_mode    <= 1'b1;
      palette_gray <= 4'h3;
      wreg(fpc_pkg::IDX_EMUL, 8'h01);
      settle();
      check({4'h0, pixel_out}, 8'h0c);
      wreg(fpc_pkg::IDX_EMUL, 8'h02);
      settle();
      check({4'h0, pixel_out}, 8'h03);
      text_mode <= 1'b0;
      settle();
      check({4'h0, pixel_out}, 8'h0c);
      {text_mode, fg_gray, bg_gray} <= {1'b1, 4'h5, 4'h3};
      wreg(fpc_pkg::IDX_EMUL, 8'h10);
      settle();
      check({fg_out, bg_out}, 8'hf0);
      wreg(fpc_pkg::IDX_IFSEL, 8'h40);
      settle();
      check({fg_out, bg_out}, 8'h53);
      {rgbi_in, palette_gray} <= 8'hf0;
      wreg(fpc_pkg::IDX_EMUL, 8'h20);
      settle();
      check({4'h0, pixel_out}, 8'h0f);
      text_mode <= 1'b0;
      wreg(fpc_pkg::IDX_EMUL, 8'h40);
      settle();
      check({4'h0, pixel_out}, 8'h0f);
      wreg(fpc_pkg::IDX_EMUL, 8'h80);
      settle();
      check({7'h00, full_cursor}, 8'h01);
      // Expansion, resolution, timing group and frame buffer modes
      {text_mode, panel_type, misc_output_reg, ext_vtiming_en} <= {1'b1, 3'h6, 2'h3, 1'b1};
      wreg(fpc_pkg::IDX_EXPBUF, 8'h3d);
      wreg(fpc_pkg::IDX_RESTIM, 8'h07);
      settle();
      check({vexpand, hexpand, char_8dot, panel_800, ext_group_480, ext_group_600,
         shadow_mono, shadow_color}, 8'hf5);
      check({6'h00, ext_fbuf, pseudo_fbuf}, 8'h02);
      {text_mode, panel_type} <= 4'h0;
      wreg(fpc_pkg::IDX_EXPBUF, 8'h18);
      wreg(fpc_pkg::IDX_RESTIM, 8'h05);
      settle();
      check({vexpand, hexpand, char_8dot, panel_800, ext_group_480, ext_group_600,
         shadow_mono, shadow_color}, 8'h1a);
      check({6'h00, ext_fbuf, pseudo_fbuf}, 8'h00);
      misc_output_reg <= 2'h2;
      settle();
      check({6'h00, ext_group_480, ext_group_600}, 8'h00);
      // Extra line clock after the upper frame, only when enabled
      for (int i = 0; i < 2; i++) begin
         wreg(fpc_pkg::IDX_EXPBUF, i[0] ? 8'h40 : 8'h00);
         settle();
         n = lines_seen;
         strobe(3'h4);
         settle();
         check(lines_seen - n, {7'h00, i[0]});
      end
      // Drive phase: once per frame at zero, else after the programmed lines
      // The period still holds the bank test pattern, so clear it first
      wreg(fpc_pkg::IDX_ACPER, 8'h00);
      settle();
      t = flips_seen;
      strobe(3'h2);
      settle();
      check(flips_seen - t, 8'h01);
      wreg(fpc_pkg::IDX_ACPER, 8'h02);
      settle();
      strobe(3'h1);
      settle();
      check(flips_seen - t, 8'h01);
      strobe(3'h1);
      settle();
      check(flips_seen - t, 8'h02);
      // Blink phase changes over 128 frames at each rate
      for (int s = 0; s < 4; s++) begin
         wreg(fpc_pkg::IDX_EMUL, 8'(s << 2));
         settle();
         n = 8'h00;
         repeat (128) begin
            b = blink_phase;
            strobe(3'h2);
            if (blink_phase !== b) n++;
         end
         check(n, 8'h10 >> s);
      end
      conclude();
   end
endmodule : tb_flat_panel_control_regs
`default_nettype wire
